// *** rtl/osc_defines.svh ***
// constants of the oscillator source select and configuration block
// assumes a 20 MHz aclk and a byte-addressed AXI4-Lite register window
`ifndef OSC_DEFINES_SVH
`define OSC_DEFINES_SVH

// bus geometry
`define OSC_ADDR_W            8
`define OSC_RESP_OKAY         2'h0
`define OSC_RESP_SLVERR       2'h2

// register byte offsets
`define OSC_OFF_CFG           8'h00
`define OSC_OFF_XLATE         8'h04
`define OSC_OFF_STATUS        8'h08
`define OSC_OFF_MASK          8'h0C

// configuration field positions
`define OSC_BYPASS_BIT        11
`define OSC_CC_MSB            9
`define OSC_CC_LSB            6
`define OSC_SRC_MSB           5
`define OSC_SRC_LSB           4
`define OSC_IVER_BIT          3
`define OSC_MVER_BIT          2
`define OSC_IOFF_BIT          1
`define OSC_MOFF_BIT          0

// configuration reset values
`define OSC_CC_RST            4'hB
`define OSC_SRC_RST           2'h0
`define OSC_BYPASS_RST        1'b1
`define OSC_BIT_RST           1'b0

// lowest crystal code usable with the pll
`define OSC_CC_PLL_MIN        4'h4

// status and mask bits
`define OSC_STAT_W            2
`define OSC_STAT_MAIN_BIT     0
`define OSC_STAT_INT_BIT      1
`define OSC_STAT_RST          2'h0
`define OSC_MASK_RST          2'h0

// translation field positions
`define OSC_XL_OD_MSB         15
`define OSC_XL_OD_LSB         14
`define OSC_XL_F_MSB          13
`define OSC_XL_F_LSB          5
`define OSC_XL_R_MSB          4
`define OSC_XL_R_LSB          0

// timing
`define OSC_CLK_PERIOD_NS     50
`define OSC_VERIFY_TIMEOUT_NS 1000
`define OSC_VERIFY_TIMEOUT_CYC \
  ((`OSC_VERIFY_TIMEOUT_NS + `OSC_CLK_PERIOD_NS - 1) / `OSC_CLK_PERIOD_NS)

`endif

// *** rtl/osc_pkg.sv ***
// types of the oscillator source select and configuration block
// assumes osc_defines.svh supplies the field positions
package osc_pkg;

  typedef enum logic [1:0] {
    OSC_SRC_MAIN     = 2'h0,
    OSC_SRC_INT      = 2'h1,
    OSC_SRC_INT_DIV4 = 2'h2,
    OSC_SRC_RSVD     = 2'h3
  } osc_src_t;

  typedef struct packed {
    logic [1:0] od;
    logic [8:0] f;
    logic [4:0] r;
  } osc_xlate_t;

endpackage : osc_pkg

// *** rtl/osc_pll_xlate.sv ***
// crystal code to pll translation values, refreshed on every code change
// assumes the code input comes straight from the configuration register
`include "osc_defines.svh"
module osc_pll_xlate #(
  parameter logic [8:0] F_BASE = 9'h000,
  parameter logic [4:0] R_BASE = 5'h00,
  parameter logic [1:0] OD_VAL = 2'h0
) (
  // clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // crystal code
  input  wire logic [3:0]          crystal_code,
  // translation outputs
  output osc_pkg::osc_xlate_t      pll_translation_values,
  output logic                     crystal_code_pll_ok
);

  function automatic osc_pkg::osc_xlate_t xlate(input logic [3:0] code);
    osc_pkg::osc_xlate_t v;
    v.od = OD_VAL;
    v.f  = F_BASE + {5'h00, code};
    v.r  = R_BASE;
    return v;
  endfunction : xlate

  logic [3:0]          last_code;
  logic [3:0]          next_last_code;
  osc_pkg::osc_xlate_t next_values;
  logic                next_ok;

  always_comb begin
    next_last_code = last_code;
    next_values    = pll_translation_values;
    next_ok        = crystal_code_pll_ok;
    if (crystal_code != last_code) begin
      next_last_code = crystal_code;
      next_values    = xlate(crystal_code);
      next_ok        = crystal_code >= `OSC_CC_PLL_MIN;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_code              <= `OSC_CC_RST;
      pll_translation_values <= xlate(`OSC_CC_RST);
      crystal_code_pll_ok    <= 1'b1;
    end else begin
      last_code              <= next_last_code;
      pll_translation_values <= next_values;
      crystal_code_pll_ok    <= next_ok;
    end
  end

  a_xlate_update: assert property (@(posedge aclk)
    disable iff (!aresetn) crystal_code != last_code |=>
      pll_translation_values == xlate($past(crystal_code)))
    else $error("translation not refreshed after code change");
  a_low_code_flag: assert property (@(posedge aclk)
    disable iff (!aresetn)
    crystal_code < `OSC_CC_PLL_MIN |=> !crystal_code_pll_ok)
    else $error("low crystal code not flagged unusable for pll");

endmodule : osc_pll_xlate

// *** rtl/osc_source_select_cfg.sv ***
// oscillator source select and configuration with an axi4-lite slave,
// verification interrupts and crystal-code translation
// assumes oscillator ticks are synchronous one-cycle pulses from the
// analog oscillator detectors and a single aclk domain
// How it works
// - four-bit crystal code in bits 9:6, read/write, feeds pll translation
// - codes 0x0 to 0x3 flagged unusable while the pll clocks the system
// - crystal code resets to 0xB, the 6 MHz crystal
// - two-bit source select in bits 5:4, reset main, 0x3 reserved
// - bit 3 enables internal oscillator verification and its interrupt
// - bit 2 enables main oscillator verification and its interrupt
// - bit 1 switches the internal oscillator off when set
// - bit 0 disables the main oscillator when set, reset enabled
// - translation values refresh whenever the crystal code changes
// - bypass set takes system clock straight from the selected oscillator
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`include "osc_defines.svh"
module osc_source_select_cfg #(
  parameter int VERIFY_TIMEOUT_CYC = `OSC_VERIFY_TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // axi4-lite write address
  input  wire logic [`OSC_ADDR_W-1:0]    awaddr,
  input  wire logic                      awvalid,
  output logic                           awready,
  // axi4-lite write data
  input  wire logic [31:0]               wdata,
  input  wire logic [3:0]                wstrb,
  input  wire logic                      wvalid,
  output logic                           wready,
  // axi4-lite write response
  output logic [1:0]                     bresp,
  output logic                           bvalid,
  input  wire logic                      bready,
  // axi4-lite read address
  input  wire logic [`OSC_ADDR_W-1:0]    araddr,
  input  wire logic                      arvalid,
  output logic                           arready,
  // axi4-lite read data
  output logic [31:0]                    rdata,
  output logic [1:0]                     rresp,
  output logic                           rvalid,
  input  wire logic                      rready,
  // oscillator activity
  input  wire logic                      main_osc_tick,
  input  wire logic                      internal_osc_tick,
  // oscillator controls
  output logic [3:0]                     crystal_code,
  output osc_pkg::osc_src_t              osc_input_select,
  output logic                           internal_osc_verify_en,
  output logic                           main_osc_verify_en,
  output logic                           internal_osc_off,
  output logic                           main_osc_off,
  output logic                           pll_bypass,
  output logic                           sysclk_direct_osc,
  // pll translation
  output osc_pkg::osc_xlate_t            pll_translation_values,
  output logic                           crystal_code_pll_ok,
  // interrupt
  output logic                           irq
);

  // write channel state
  logic                      aw_have, next_aw_have, w_have, next_w_have;
  logic [`OSC_ADDR_W-1:0]    aw_addr, next_aw_addr;
  logic [31:0]               w_data, next_w_data;
  logic [3:0]                w_strb, next_w_strb;
  logic                      next_bvalid;
  logic [1:0]                next_bresp;
  // read channel state
  logic                      next_rvalid;
  logic [31:0]               next_rdata;
  logic [1:0]                next_rresp;
  // configuration state
  logic [3:0]                next_crystal_code;
  osc_pkg::osc_src_t         next_osc_input_select;
  logic                      next_internal_osc_verify_en, next_pll_bypass;
  logic                      next_main_osc_verify_en, next_main_osc_off;
  logic                      next_internal_osc_off;
  // interrupt state
  logic [`OSC_STAT_W-1:0]    status, next_status, mask, next_mask, events;
  // decode and events
  logic                      do_write, wr_cfg, wr_mask, rd_take, rd_stat;
  logic [31:0]               byte_mask, cfg_word, cfg_merged, mask_merged;
  logic                      main_fail, int_fail;
  function automatic logic [`OSC_ADDR_W-1:0] word_addr(
    input logic [`OSC_ADDR_W-1:0] a);
    return {a[`OSC_ADDR_W-1:2], 2'h0};
  endfunction : word_addr
  function automatic logic mapped(input logic [`OSC_ADDR_W-1:0] a);
    logic [`OSC_ADDR_W-1:0] w;
    w = word_addr(a);
    return (w == `OSC_OFF_CFG) || (w == `OSC_OFF_XLATE) ||
           (w == `OSC_OFF_STATUS) || (w == `OSC_OFF_MASK);
  endfunction : mapped
  // verification timers
  osc_verify_timer #(
    .TIMEOUT_CYC (VERIFY_TIMEOUT_CYC)
  ) u_main_verify (
    .aclk    (aclk),
    .aresetn (aresetn),
    .enable  (main_osc_verify_en),
    .tick    (main_osc_tick),
    .fault   (main_fail)
  );
  osc_verify_timer #(
    .TIMEOUT_CYC (VERIFY_TIMEOUT_CYC)
  ) u_int_verify (
    .aclk    (aclk),
    .aresetn (aresetn),
    .enable  (internal_osc_verify_en),
    .tick    (internal_osc_tick),
    .fault   (int_fail)
  );
  // crystal code translation
  osc_pll_xlate u_xlate (
    .aclk                   (aclk),
    .aresetn                (aresetn),
    .crystal_code           (crystal_code),
    .pll_translation_values (pll_translation_values),
    .crystal_code_pll_ok    (crystal_code_pll_ok)
  );
  // configuration word as read back
  always_comb begin
    cfg_word = 32'h0000_0000;
    cfg_word[`OSC_BYPASS_BIT]           = pll_bypass;
    cfg_word[`OSC_CC_MSB:`OSC_CC_LSB]   = crystal_code;
    cfg_word[`OSC_SRC_MSB:`OSC_SRC_LSB] = osc_input_select;
    cfg_word[`OSC_IVER_BIT]             = internal_osc_verify_en;
    cfg_word[`OSC_MVER_BIT]             = main_osc_verify_en;
    cfg_word[`OSC_IOFF_BIT]             = internal_osc_off;
    cfg_word[`OSC_MOFF_BIT]             = main_osc_off;
  end
  assign byte_mask   = {{8{w_strb[3]}}, {8{w_strb[2]}},
                        {8{w_strb[1]}}, {8{w_strb[0]}}};
  assign cfg_merged  = (cfg_word & ~byte_mask) | (w_data & byte_mask);
  assign mask_merged = ({30'h0, mask} & ~byte_mask) | (w_data & byte_mask);
  assign do_write    = aw_have && w_have && !bvalid;
  assign wr_cfg      = do_write && word_addr(aw_addr) == `OSC_OFF_CFG;
  assign wr_mask     = do_write && word_addr(aw_addr) == `OSC_OFF_MASK;
  assign awready     = !aw_have;
  assign wready      = !w_have;
  assign arready     = !rvalid;
  assign rd_take     = arvalid && arready;
  assign rd_stat     = rd_take && word_addr(araddr) == `OSC_OFF_STATUS;

  // write channel: address and data taken in either order
  always_comb begin
    next_aw_have = aw_have;
    next_aw_addr = aw_addr;
    next_w_have  = w_have;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    if (awvalid && awready) begin
      next_aw_have = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_have = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    if (do_write) begin
      next_aw_have = 1'b0;
      next_w_have  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = mapped(aw_addr) ? `OSC_RESP_OKAY : `OSC_RESP_SLVERR;
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
  end

  // read channel
  always_comb begin
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (rd_take) begin
      next_rvalid = 1'b1;
      next_rresp  = mapped(araddr) ? `OSC_RESP_OKAY : `OSC_RESP_SLVERR;
      case (word_addr(araddr))
        `OSC_OFF_CFG:    next_rdata = cfg_word;
        `OSC_OFF_XLATE:  next_rdata = {16'h0000, pll_translation_values};
        `OSC_OFF_STATUS: next_rdata = {30'h0, status};
        `OSC_OFF_MASK:   next_rdata = {30'h0, mask};
        default:         next_rdata = 32'h0000_0000;
      endcase
    end else if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      aw_addr <= '0;
      w_have  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= `OSC_RESP_OKAY;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `OSC_RESP_OKAY;
    end else begin
      aw_have <= next_aw_have;
      aw_addr <= next_aw_addr;
      w_have  <= next_w_have;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
    end
  end

  // configuration fields
  always_comb begin
    next_crystal_code           = crystal_code;
    next_osc_input_select       = osc_input_select;
    next_internal_osc_verify_en = internal_osc_verify_en;
    next_main_osc_verify_en     = main_osc_verify_en;
    next_internal_osc_off       = internal_osc_off;
    next_main_osc_off           = main_osc_off;
    next_pll_bypass             = pll_bypass;
    if (wr_cfg) begin
      next_crystal_code     = cfg_merged[`OSC_CC_MSB:`OSC_CC_LSB];
      next_osc_input_select = osc_pkg::osc_src_t'(
        cfg_merged[`OSC_SRC_MSB:`OSC_SRC_LSB]);
      next_internal_osc_verify_en = cfg_merged[`OSC_IVER_BIT];
      next_main_osc_verify_en     = cfg_merged[`OSC_MVER_BIT];
      next_internal_osc_off       = cfg_merged[`OSC_IOFF_BIT];
      next_main_osc_off           = cfg_merged[`OSC_MOFF_BIT];
      next_pll_bypass             = cfg_merged[`OSC_BYPASS_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crystal_code           <= `OSC_CC_RST;
      osc_input_select       <= osc_pkg::OSC_SRC_MAIN;
      internal_osc_verify_en <= `OSC_BIT_RST;
      main_osc_verify_en     <= `OSC_BIT_RST;
      internal_osc_off       <= `OSC_BIT_RST;
      main_osc_off           <= `OSC_BIT_RST;
      pll_bypass             <= `OSC_BYPASS_RST;
    end else begin
      crystal_code           <= next_crystal_code;
      osc_input_select       <= next_osc_input_select;
      internal_osc_verify_en <= next_internal_osc_verify_en;
      main_osc_verify_en     <= next_main_osc_verify_en;
      internal_osc_off       <= next_internal_osc_off;
      main_osc_off           <= next_main_osc_off;
      pll_bypass             <= next_pll_bypass;
    end
  end

  // system clock path follows the bypass bit
  assign sysclk_direct_osc = pll_bypass;

  // sticky status, cleared by a read, new events win over the clear
  always_comb begin
    events = '0;
    events[`OSC_STAT_MAIN_BIT] = main_fail;
    events[`OSC_STAT_INT_BIT]  = int_fail;
    next_status = (rd_stat ? '0 : status) | events;
    next_mask   = wr_mask ? mask_merged[`OSC_STAT_W-1:0] : mask;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= `OSC_STAT_RST;
      mask   <= `OSC_MASK_RST;
    end else begin
      status <= next_status;
      mask   <= next_mask;
    end
  end

  assign irq = |(status & mask);

  a_reset_code: assert property (@(posedge aclk)
    !aresetn |=> crystal_code == `OSC_CC_RST)
    else $error("crystal code did not reset to its default");
  a_reset_fields: assert property (@(posedge aclk)
    !aresetn |=> osc_input_select == osc_pkg::OSC_SRC_MAIN &&
      !main_osc_off && !internal_osc_off)
    else $error("source or disable bits wrong after reset");
  a_code_write: assert property (@(posedge aclk)
    disable iff (!aresetn) wr_cfg |=>
      crystal_code == $past(cfg_merged[`OSC_CC_MSB:`OSC_CC_LSB]))
    else $error("crystal code not stored on write");
  a_src_write: assert property (@(posedge aclk)
    disable iff (!aresetn) wr_cfg |=>
      osc_input_select == $past(cfg_merged[`OSC_SRC_MSB:`OSC_SRC_LSB]))
    else $error("source select not stored on write");
  a_cfg_hold: assert property (@(posedge aclk)
    disable iff (!aresetn) !wr_cfg |=> $stable(cfg_word))
    else $error("configuration changed without a write");
  a_ioff_bit: assert property (@(posedge aclk)
    disable iff (!aresetn) wr_cfg |=>
      internal_osc_off == $past(cfg_merged[`OSC_IOFF_BIT]))
    else $error("internal oscillator off bit lost");
  a_moff_bit: assert property (@(posedge aclk)
    disable iff (!aresetn) wr_cfg |=>
      main_osc_off == $past(cfg_merged[`OSC_MOFF_BIT]))
    else $error("main oscillator off bit lost");
  a_main_irq: assert property (@(posedge aclk)
    disable iff (!aresetn) main_fail && mask[`OSC_STAT_MAIN_BIT] |=> irq)
    else $error("main oscillator fault raised no interrupt");
  a_int_sticky: assert property (@(posedge aclk)
    disable iff (!aresetn) int_fail |=> status[`OSC_STAT_INT_BIT] [*2] or
      (status[`OSC_STAT_INT_BIT] ##1 $past(rd_stat)))
    else $error("internal oscillator fault not held");
  a_bypass_path: assert property (@(posedge aclk)
    disable iff (!aresetn) wr_cfg |=>
      sysclk_direct_osc == $past(cfg_merged[`OSC_BYPASS_BIT]))
    else $error("system clock path ignores bypass write");

  c_cfg_write: cover property (@(posedge aclk) disable iff (!aresetn)
    wr_cfg ##1 bvalid && bready);
  c_main_fault: cover property (@(posedge aclk) disable iff (!aresetn)
    main_fail ##1 irq);
  c_int_fault: cover property (@(posedge aclk) disable iff (!aresetn)
    int_fail);
  c_stat_clear: cover property (@(posedge aclk) disable iff (!aresetn)
    irq ##1 rd_stat ##1 !irq);

endmodule : osc_source_select_cfg

// *** rtl/osc_verify_timer.sv ***
// oscillator verification timer: flags a fault when no oscillator tick
// arrives within the timeout while enabled
// assumes tick is a one-cycle pulse synchronous to aclk
`include "osc_defines.svh"
module osc_verify_timer #(
  parameter int TIMEOUT_CYC = `OSC_VERIFY_TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // oscillator side
  input  wire logic enable,
  input  wire logic tick,
  // fault pulse
  output logic      fault
);

  localparam int CW = $clog2(TIMEOUT_CYC + 1);
  localparam logic [CW-1:0] LIMIT = CW'(TIMEOUT_CYC);
  localparam logic [CW-1:0] LAST  = CW'(TIMEOUT_CYC - 1);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;

  // counting stops at the limit so one outage gives one fault
  always_comb begin
    next_count = count;
    if (!enable || tick) begin
      next_count = '0;
    end else if (count != LIMIT) begin
      next_count = count + CW'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign fault = enable && !tick && (count == LAST);

  a_fault_single: assert property (@(posedge aclk)
    disable iff (!aresetn) fault |=> !fault)
    else $error("fault pulse lasted more than one cycle");
  a_off_silent: assert property (@(posedge aclk)
    disable iff (!aresetn) !enable |=> count == '0)
    else $error("timer counted while disabled");

endmodule : osc_verify_timer

// *** tb/osc_source_select_cfg_tb.sv ***
// testbench of the oscillator source select and configuration block
// assumes the rtl files and osc_defines.svh are compiled before it
`include "osc_defines.svh"
module osc_source_select_cfg_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                   aclk, aresetn;
  logic [`OSC_ADDR_W-1:0] awaddr, araddr;
  logic                   awvalid, wvalid, bready, arvalid, rready;
  logic [31:0]            wdata, rdata, seed, cfg;
  logic [3:0]             wstrb, crystal_code;
  logic                   awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]             bresp, rresp, tick_en;
  logic                   main_osc_tick, internal_osc_tick;
  osc_pkg::osc_src_t      osc_input_select;
  logic                   internal_osc_verify_en, main_osc_verify_en;
  logic                   internal_osc_off, main_osc_off;
  logic                   pll_bypass, sysclk_direct_osc, crystal_code_pll_ok;
  osc_pkg::osc_xlate_t    pll_translation_values;
  logic [33:0]            rq[$];
  logic [1:0]             wq[$];
  int                     err_total, cmp_count;

  osc_source_select_cfg #(.VERIFY_TIMEOUT_CYC(4)) DUT (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .main_osc_tick(main_osc_tick), .internal_osc_tick(internal_osc_tick),
    .crystal_code(crystal_code), .osc_input_select(osc_input_select),
    .internal_osc_verify_en(internal_osc_verify_en),
    .main_osc_verify_en(main_osc_verify_en),
    .internal_osc_off(internal_osc_off), .main_osc_off(main_osc_off),
    .pll_bypass(pll_bypass), .sysclk_direct_osc(sysclk_direct_osc),
    .pll_translation_values(pll_translation_values),
    .crystal_code_pll_ok(crystal_code_pll_ok), .irq(irq));

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs

  task automatic give_verdict;
    $display("mismatches %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  task automatic cmp(input logic [33:0] g, input logic [33:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp

  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [3:0] s, input logic [1:0] e);
    logic ta, tw, tb;
    int   n;
    wq.push_back(e);
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= v;
    wstrb   <= s;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) begin
        bready <= 1'b0;
        break;
      end
    end
    if (n == 40) cmp(34'h0, 34'h1);
    if (n == 40) give_verdict();
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [1:0] e,
                    input logic [31:0] v);
    logic ta, tr;
    int   n;
    rq.push_back({e, v});
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid && rready;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) begin
        rready <= 1'b0;
        break;
      end
    end
    if (n == 40) cmp(34'h0, 34'h1);
    if (n == 40) give_verdict();
  endtask : rd

  task automatic chk_cfg;
    rd(8'h00, 2'h0, cfg & 32'hBFF);
    rd(8'h04, 2'h0, {23'h0, cfg[9:6], 5'h0});
    @(negedge aclk);
    cmp({22'h0, pll_bypass, sysclk_direct_osc, crystal_code, osc_input_select,
         internal_osc_verify_en, main_osc_verify_en, internal_osc_off,
         main_osc_off}, {22'h0, cfg[11], cfg[11], cfg[9:0]});
    cmp({17'h0, crystal_code_pll_ok, pll_translation_values},
        {17'h0, cfg[9:6] >= 4'h4, 7'h0, cfg[9:6], 5'h0});
  endtask : chk_cfg

  task automatic irq_is(input logic e);
    repeat (10) @(posedge aclk);
    @(negedge aclk);
    cmp({33'h0, irq}, {33'h0, e});
  endtask : irq_is

  // results are compared in the order they were requested
  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready === 1'b1 && rq.size() > 0)
      cmp({rresp, rdata}, rq.pop_front());
    if (bvalid === 1'b1 && bready === 1'b1 && wq.size() > 0)
      cmp({32'h0, bresp}, {32'h0, wq.pop_front()});
  end

  // activity pulses every other cycle while enabled
  always @(posedge aclk) begin
    main_osc_tick     <= tick_en[0] & ~main_osc_tick;
    internal_osc_tick <= tick_en[1] & ~internal_osc_tick;
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    {main_osc_tick, internal_osc_tick, tick_en} = 4'h0;
    seed = 32'h5A83;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    cfg = 32'h0000_0AC0;
    chk_cfg();
    tick_en <= 2'h3;
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      cfg = {seed[31:6], i[1:0], seed[3:0]};
      cfg[11] = cfg[11] | (cfg[9:6] < 4'h4) | (cfg[5:4] == 2'h1);
      wr(8'h00, cfg, 4'hF, 2'h0);
      chk_cfg();
    end
    wr(8'h00, 32'h0000_00FF, 4'h1, 2'h0);
    cfg = {cfg[31:8], 8'hFF};
    chk_cfg();
    cfg = 32'h0000_08F0;
    wr(8'h00, cfg, 4'hF, 2'h0);
    chk_cfg();
    cfg = 32'h0000_01A0;
    wr(8'h00, cfg, 4'hF, 2'h0);
    chk_cfg();
    wr(8'h10, 32'hFFFF_FFFF, 4'hF, 2'h2);
    rd(8'h10, 2'h2, 32'h0);
    wr(8'h0C, 32'h3, 4'hF, 2'h0);
    rd(8'h0C, 2'h0, 32'h3);
    wr(8'h00, 32'h0000_0ACC, 4'hF, 2'h0);
    irq_is(1'b0);
    tick_en <= 2'h2;
    irq_is(1'b1);
    wr(8'h00, 32'h0000_0AC8, 4'hF, 2'h0);
    rd(8'h08, 2'h0, 32'h1);
    rd(8'h08, 2'h0, 32'h0);
    wr(8'h0C, 32'h1, 4'hF, 2'h0);
    tick_en <= 2'h0;
    irq_is(1'b0);
    wr(8'h00, 32'h0000_0AC0, 4'hF, 2'h0);
    rd(8'h08, 2'h0, 32'h2);
    repeat (10) @(posedge aclk);
    rd(8'h08, 2'h0, 32'h0);
    give_verdict();
  end
endmodule : osc_source_select_cfg_tb
